//--- core/strap_consts.svh
// Constants for the reset strap and mode configuration block
`ifndef STRAP_CONSTS_SVH
`define STRAP_CONSTS_SVH
// Identity values, arbitrary neutral codes
`define ID_PART_VALUE      12'h0_A5C
`define ID_REV_VALUE       4'h1
// I2C address base, low two bits come from the interface straps
`define I2C_ADDR_BASE      7'h70
// Interface code that selects the SPI slave
`define IFACE_SPI_CODE     2'h3
// Analog-loop mux codes
`define MUX_DIGITAL_MSBS   2'h3
// Capture status reset value
`define CAPTURE_RESET      5'h00
// Status field positions inside strap_capture_status
`define CAP_IF_LSB         0
`define CAP_AC_LSB         2
`define CAP_TEST_BIT       4
`endif

//--- core/strap_pkg.sv
// Types for the reset strap and mode configuration block
package strap_pkg;
   // Operating mode of the whole device
   typedef enum logic [1:0] {
      MODE_APLL_ONLY,
      MODE_DPLL_JA,
      MODE_DPLL_NCO,
      MODE_INVALID
   } top_mode_t;
   // Post-reset pin role
   typedef enum logic [1:0] {
      PIN_STRAP,
      PIN_GPIO,
      PIN_SERIAL
   } pin_role_t;
endpackage : strap_pkg

//--- core/pin_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 6
) (
   input  wire logic             ref_clk_in,
   input  wire logic             sys_rst_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   // State: both stages in one struct
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_t;
   sync_state_t st_q;
   sync_state_t st_d;

   // Next state: first stage only feeds the second
   always_comb
   begin
      st_d.meta   = async_in;
      st_d.stable = st_q.meta;
   end

   // Register both stages
   always_ff @(posedge ref_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign sync_out = st_q.stable;
endmodule : pin_sync
`default_nettype wire

//--- core/strap_mode_config.sv
// Reset strap capture and top-level mode selection
// Functional notes
// - Read-only 12-bit identity, 4-bit revision fields
// - Digital loop off powers down input, DPLL
// - Mux code 0xx means analog-PLL-only mode
// - APLL-only disables monitoring and hitless switching
// - DPLL+APLL needs mux 11x and enable
// - DPLL+APLL jitter sub-mode enables monitors, switching, holdover
// - Jitter sub-mode: DPLL locks one input
// - NCO sub-mode: inputs off, host sets frequency
// - Five straps sampled at reset pin rising
// - After reset, strap pins take second function
// - Sampled straps captured into status register
// - Test strap high: autoconfig picks test mode
// - Test high, autoconfig 00: EEPROM programmer access
// - Interface straps pick I2C address or SPI
// - Autoconfig straps pick stored configuration 0-3
`timescale 1ns/1ps
`default_nettype none
`include "strap_consts.svh"
module strap_mode_config
   import strap_pkg::*;
(
   input  wire logic        ref_clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        active_low_reset_pin_in,
   input  wire logic        test_strap_in,
   input  wire logic [1:0]  autoconfig_select_straps_in,
   input  wire logic [1:0]  iface_straps_in,
   input  wire logic        digital_loop_enable_in,
   input  wire logic [2:0]  analog_loop_input_select_in,
   input  wire logic        nco_select_in,
   output logic [15:0]      identity_reg_low_out,
   output logic [15:0]      identity_reg_high_out,
   output logic [4:0]       strap_capture_status_out,
   output logic             strap_pins_released_out,
   output logic             spi_slave_sel_out,
   output logic [6:0]       i2c_address_out,
   output logic [1:0]       config_index_out,
   output logic             factory_test_out,
   output logic [1:0]       test_mode_out,
   output logic             eeprom_prog_access_out,
   output logic             config_load_start_out,
   output logic [1:0]       top_mode_out,
   output logic             input_block_power_out,
   output logic             dpll_power_out,
   output logic             monitors_enable_out,
   output logic             ref_switch_enable_out,
   output logic             holdover_enable_out,
   output logic             nco_active_out
);

   // Synchronised pins: reset pin plus five straps
   logic [5:0] pins_sync;

   // Pins pass two flops before any logic looks at them
   pin_sync #(
      .WIDTH (6)
   ) u_pin_sync (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .async_in   ({active_low_reset_pin_in, test_strap_in,
                    autoconfig_select_straps_in, iface_straps_in}),
      .sync_out   (pins_sync)
   );

   // Decodes the top mode from the control bits
   function automatic top_mode_t decode_mode(input logic dl_en, input logic [2:0] mux,
                                              input logic nco);
      top_mode_t m;
      m = MODE_INVALID;
      if (!mux[2])
      begin
         m = MODE_APLL_ONLY;
      end
      else if (!dl_en)
      begin
         m = MODE_APLL_ONLY;
      end
      // mux 11x with enable gives DPLL+APLL
      else if (mux[2:1] == `MUX_DIGITAL_MSBS)
      begin
         m = nco ? MODE_DPLL_NCO : MODE_DPLL_JA;
      end
      return m;
   endfunction : decode_mode

   // All state of the block except the identity registers
   typedef struct packed {
      logic       rst_pin_prev;   // Last synced reset pin level
      logic [4:0] capture;        // Captured straps: test, ac, if
      logic       released;       // Pins now in second function
      logic       load_start;     // One-cycle config load pulse
      top_mode_t  mode;           // Registered operating mode
      logic [6:0] i2c_addr;       // Selected I2C address
      logic       spi_sel;        // SPI slave selected
      logic       prog_access;    // EEPROM programmer mode
      logic       in_pwr;         // Input block powered
      logic       dpll_pwr;       // DPLL powered
      logic       mon_en;         // Activity/frequency monitors
      logic       sw_en;          // Reference and hitless switching
      logic       hold_en;        // Holdover
      logic       nco_act;        // NCO sub-mode active
   } state_t;
   state_t st_q;
   state_t st_d;

   // Next-state logic
   always_comb
   begin
      st_d            = st_q;
      st_d.load_start = 1'b0;
      st_d.rst_pin_prev = pins_sync[5];
      // sample straps on rising edge of reset pin
      if (pins_sync[5] && !st_q.rst_pin_prev)
      begin
         st_d.capture    = pins_sync[4:0];
         st_d.released   = 1'b1;
         st_d.load_start = !pins_sync[`CAP_TEST_BIT];
      end
      // back to strap role while reset pin low
      else if (!pins_sync[5])
      begin
         st_d.released = 1'b0;
      end
      // capture held otherwise, no write path exists
      st_d.spi_sel  = (st_d.capture[`CAP_IF_LSB +: 2] == `IFACE_SPI_CODE);
      st_d.i2c_addr = `I2C_ADDR_BASE | {5'h00, st_d.capture[`CAP_IF_LSB +: 2]};
      // programmer access on test high and 00
      st_d.prog_access = st_d.capture[`CAP_TEST_BIT] &&
                         (st_d.capture[`CAP_AC_LSB +: 2] == 2'h0);
      st_d.mode = decode_mode(digital_loop_enable_in, analog_loop_input_select_in,
                              nco_select_in);
      st_d.in_pwr   = 1'b0;
      st_d.dpll_pwr = 1'b0;
      st_d.mon_en   = 1'b0;
      st_d.sw_en    = 1'b0;
      st_d.hold_en  = 1'b0;
      st_d.nco_act  = 1'b0;
      case (st_d.mode)
         MODE_DPLL_JA:
         begin
            st_d.in_pwr   = 1'b1;
            st_d.dpll_pwr = 1'b1;
            st_d.mon_en   = 1'b1;
            st_d.sw_en    = 1'b1;
            st_d.hold_en  = 1'b1;
         end
         // NCO keeps only the DPLL core running
         MODE_DPLL_NCO:
         begin
            st_d.dpll_pwr = 1'b1;
            st_d.nco_act  = 1'b1;
         end
         MODE_APLL_ONLY:
         begin
            // input block and DPLL stay off
            st_d.dpll_pwr = 1'b0;
         end
         default:
         begin
            // Mux 10x with digital loop on: keep all off
            st_d.nco_act = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge ref_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         st_q <= '{rst_pin_prev: 1'b0, capture: `CAPTURE_RESET, released: 1'b0,
                   load_start: 1'b0, mode: MODE_APLL_ONLY, i2c_addr: `I2C_ADDR_BASE,
                   spi_sel: 1'b0, prog_access: 1'b0, in_pwr: 1'b0, dpll_pwr: 1'b0,
                   mon_en: 1'b0, sw_en: 1'b0, hold_en: 1'b0, nco_act: 1'b0};
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Identity registers are constants, so they are flops held at reset value
   logic [15:0] id_low_q;
   logic [15:0] id_high_q;
   always_ff @(posedge ref_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         id_low_q  <= {4'h0, `ID_PART_VALUE};
         id_high_q <= {12'h000, `ID_REV_VALUE};
      end
      else
      begin
         id_low_q  <= {4'h0, `ID_PART_VALUE};
         id_high_q <= {12'h000, `ID_REV_VALUE};
      end
   end

   // Outputs straight from flops
   assign identity_reg_low_out     = id_low_q;
   assign identity_reg_high_out    = id_high_q;
   assign strap_capture_status_out = st_q.capture;
   assign strap_pins_released_out  = st_q.released;
   assign spi_slave_sel_out        = st_q.spi_sel;
   assign i2c_address_out          = st_q.i2c_addr;
   // autoconfig bits drive test select and config index alike; test strap only flags test
   assign factory_test_out         = st_q.capture[`CAP_TEST_BIT];
   assign test_mode_out            = st_q.capture[`CAP_AC_LSB +: 2];
   assign config_index_out         = st_q.capture[`CAP_AC_LSB +: 2];
   assign eeprom_prog_access_out   = st_q.prog_access;
   assign config_load_start_out    = st_q.load_start;
   assign top_mode_out             = st_q.mode;
   assign input_block_power_out    = st_q.in_pwr;
   assign dpll_power_out           = st_q.dpll_pwr;
   assign monitors_enable_out      = st_q.mon_en;
   assign ref_switch_enable_out    = st_q.sw_en;
   assign holdover_enable_out      = st_q.hold_en;
   assign nco_active_out           = st_q.nco_act;

   // Reset pin rise seen one cycle before capture
   sequence s_pin_rise;
      pins_sync[5] && !st_q.rst_pin_prev;
   endsequence

   a_capture_on_rise: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      s_pin_rise |=> (st_q.capture == $past(pins_sync[4:0]) && st_q.released))
      else $error("strap capture missed");
   a_capture_holds: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !(pins_sync[5] && !st_q.rst_pin_prev) |=> $stable(st_q.capture))
      else $error("capture changed without reset edge");
   a_sample_edge: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      $changed(st_q.capture) |-> $past(pins_sync[5] && !st_q.rst_pin_prev))
      else $error("capture outside reset edge");
   a_role_release: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !pins_sync[5] |=> !st_q.released)
      else $error("pins released while reset held");
   a_spi_decode: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      spi_slave_sel_out == (strap_capture_status_out[1:0] == 2'h3) &&
      i2c_address_out == {5'h1C, strap_capture_status_out[1:0]})
      else $error("interface decode wrong");
   a_prog_access: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      eeprom_prog_access_out == (strap_capture_status_out[4] && strap_capture_status_out[3:2] == 2'h0))
      else $error("programmer access wrong");
   a_analog_only: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !analog_loop_input_select_in[2] |=> top_mode_out == MODE_APLL_ONLY && !dpll_power_out)
      else $error("analog-only mode not entered");
   a_loop_off: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !digital_loop_enable_in |=> !input_block_power_out && !dpll_power_out && !monitors_enable_out)
      else $error("digital loop not powered down");
   a_dpll_mode: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (top_mode_out == MODE_DPLL_JA) |-> $past(digital_loop_enable_in && analog_loop_input_select_in[2:1] == 2'h3))
      else $error("dpll mode without cause");
   a_ja_features: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (top_mode_out == MODE_DPLL_JA) |-> monitors_enable_out && ref_switch_enable_out && holdover_enable_out)
      else $error("jitter mode features off");
   a_nco_inputs: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      nco_active_out |-> !input_block_power_out && dpll_power_out)
      else $error("nco power wrong");

   // Controls that ask for DPLL+APLL with the jitter filter
   sequence s_ja_request;
      digital_loop_enable_in && analog_loop_input_select_in[2:1] == 2'h3 && !nco_select_in;
   endsequence

   // Controls that ask for DPLL+APLL with the NCO
   sequence s_nco_request;
      digital_loop_enable_in && analog_loop_input_select_in[2:1] == 2'h3 && nco_select_in;
   endsequence

   // jitter request powers input block and DPLL
   a_ja_power: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      s_ja_request |=> top_mode_out == MODE_DPLL_JA && input_block_power_out && dpll_power_out)
      else $error("jitter mode power wrong");
   // NCO request enters the NCO sub-mode
   a_nco_entry: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      s_nco_request |=> top_mode_out == MODE_DPLL_NCO && nco_active_out && !monitors_enable_out)
      else $error("nco mode not entered");
   // analog-only mode keeps input features off
   a_apll_features: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      top_mode_out == MODE_APLL_ONLY |-> !monitors_enable_out && !ref_switch_enable_out && !holdover_enable_out)
      else $error("analog-only features on");
   a_load_pulse: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      config_load_start_out |=> !config_load_start_out)
      else $error("load pulse too long");
   a_test_mode: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      factory_test_out |-> !config_load_start_out)
      else $error("config load in test mode");
   a_identity: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      $stable(identity_reg_low_out) && $stable(identity_reg_high_out))
      else $error("identity changed");
endmodule : strap_mode_config
`default_nettype wire

//--- test/strap_board.sv
// Board strap resistors and host select line driving the shared strap pins
`timescale 1ns/1ps
`default_nettype none
module strap_board (
   input  wire logic       ref_clk_in,
   input  wire logic       reset_pin_in,
   input  wire logic [4:0] strap_val_in,
   output logic      [4:0] strap_pins_out
);
   logic [3:0] hold_q; // Cycles since the reset pin rose

   // Count the strap hold time after the reset pin rises
   always_ff @(posedge ref_clk_in)
   begin
      if (!reset_pin_in)
         hold_q <= 4'h0;
      else if (hold_q != 4'hF)
         hold_q <= hold_q + 4'h1;
   end

   // resistors hold the level over the rise
   // host pulls the select pin low in SPI mode
   // Pins reused afterwards toggle, so a stale capture path shows up
   always_ff @(posedge ref_clk_in)
   begin
      if (!reset_pin_in || hold_q < 4'h6)
         strap_pins_out <= strap_val_in;
      else
         strap_pins_out <= {~strap_pins_out[4:1], (strap_val_in[1:0] == 2'h3) ? 1'h0 : ~strap_pins_out[0]};
   end
endmodule : strap_board
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for strap capture and mode selection
`timescale 1ns/1ps
`default_nettype none
`include "strap_consts.svh"
module tb;
   logic        ref_clk_in;  // Bench clock
   logic        sys_rst_in;  // Block reset
   logic        pin;         // Device reset pin, low active
   logic [4:0]  val;         // Requested strap levels
   logic [4:0]  pins;        // Strap pins from the board
   logic        dle;         // Digital loop enable
   logic [2:0]  mux;         // Analog loop input select
   logic        nco;         // NCO sub-mode select
   logic [15:0] id_lo;       // Identity low register
   logic [15:0] id_hi;       // Identity high register
   logic [4:0]  status;      // Captured straps
   logic        released;    // Pins in second function
   logic        spi;         // SPI slave chosen
   logic [6:0]  i2c;         // I2C address
   logic [1:0]  cfg;         // Stored configuration index
   logic        ftest;       // Factory test
   logic [1:0]  tmode;       // Test mode
   logic        prog;        // Memory programmer access
   logic        load;        // Configuration load pulse
   logic [1:0]  mode;        // Top mode
   logic        inpw;        // Input block power
   logic        dpw;         // Digital loop power
   logic        mon;         // Monitors
   logic        sw;          // Reference switching
   logic        hold;        // Holdover
   logic        ncoa;        // NCO active
   int          errors;      // Mismatch count
   int          checks;      // Comparison count

   strap_board u_strap_board (.ref_clk_in(ref_clk_in), .reset_pin_in(pin), .strap_val_in(val),
      .strap_pins_out(pins));

   strap_mode_config u_strap_mode_config (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .active_low_reset_pin_in(pin), .test_strap_in(pins[4]), .autoconfig_select_straps_in(pins[3:2]),
      .iface_straps_in(pins[1:0]), .digital_loop_enable_in(dle), .analog_loop_input_select_in(mux),
      .nco_select_in(nco), .identity_reg_low_out(id_lo), .identity_reg_high_out(id_hi),
      .strap_capture_status_out(status), .strap_pins_released_out(released), .spi_slave_sel_out(spi),
      .i2c_address_out(i2c), .config_index_out(cfg), .factory_test_out(ftest), .test_mode_out(tmode),
      .eeprom_prog_access_out(prog), .config_load_start_out(load), .top_mode_out(mode),
      .input_block_power_out(inpw), .dpll_power_out(dpw), .monitors_enable_out(mon),
      .ref_switch_enable_out(sw), .holdover_enable_out(hold), .nco_active_out(ncoa));

   // Free-running 100 MHz clock
   // stands for a master clock inside the valid range
   // no crystal and no doubler, the clock is fed in directly
   always #5 ref_clk_in = ~ref_clk_in;

   // Compare one value and count the result
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
   begin
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask : check

   // One reset pin cycle with the given straps, then decoded outputs
   task automatic strap_run(input logic [4:0] v);
   begin
      @(posedge ref_clk_in);
      pin <= 1'h0;
      val <= v;
      repeat (6) @(posedge ref_clk_in);
      #1;
      check(released, 1'h0);
      @(posedge ref_clk_in);
      pin <= 1'h1;
      repeat (3) @(posedge ref_clk_in);
      #1;
      check(status, v);
      check(released, 1'h1);
      check(load, !v[4]);
      check(spi, v[1:0] == 2'h3);
      if (v[1:0] != 2'h3)
         check(i2c, `I2C_ADDR_BASE | v[1:0]);
      check(cfg, v[3:2]);
      check(ftest, v[4]);
      if (v[4])
         check(tmode, v[3:2]);
      check(prog, v[4] && v[3:2] == 2'h0);
      @(posedge ref_clk_in);
      #1;
      check(load, 1'h0);
      // Board now toggles the reused pins; capture must hold
      repeat (10) @(posedge ref_clk_in);
      #1;
      check(status, v);
      check(cfg, v[3:2]);
   end
   endtask : strap_run

   // Apply mode controls and compare the enables
   task automatic mode_run(input logic [2:0] m, input logic e, input logic n);
   begin
      @(posedge ref_clk_in);
      mux <= m;
      dle <= e;
      nco <= n;
      repeat (2) @(posedge ref_clk_in);
      #1;
      if (!m[2] || !e)
      begin
         check({inpw, dpw, mon, sw, hold, ncoa}, 6'h00);
         check(mode, 2'h0);
      end
      else if (!m[1])
         check({mode, inpw, dpw, mon, sw, hold, ncoa}, {2'h3, 6'h00});
      else if (n)
         check({mode, inpw, ncoa}, {2'h2, 2'h1});
      else
         check({mode, inpw, dpw, mon, sw, hold, ncoa}, {2'h1, 6'h3E});
   end
   endtask : mode_run

   // Print the counts and the verdict, then stop
   task automatic finish_test;
   begin
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask : finish_test

   // Main sequence: every strap code, random codes, every mode code
   initial
   begin
      ref_clk_in = 1'h0;
      sys_rst_in = 1'h1;
      pin = 1'h0;
      val = 5'h00;
      dle = 1'h0;
      mux = 3'h0;
      nco = 1'h0;
      errors = 0;
      checks = 0;
      void'($urandom(13));
      repeat (3) @(posedge ref_clk_in);
      sys_rst_in <= 1'h0;
      #1;
      check(status, 5'h00);
      check(id_lo, {4'h0, `ID_PART_VALUE});
      check(id_hi, {12'h000, `ID_REV_VALUE});
      for (int i = 0; i < 32; i++)
         strap_run(i[4:0]);
      repeat (8)
         strap_run(5'($urandom));
      for (int i = 0; i < 32; i++)
         mode_run(i[4:2], i[1], i[0]);
      repeat (16)
         mode_run(3'($urandom), 1'($urandom), 1'($urandom));
      check(id_lo, {4'h0, `ID_PART_VALUE});
      finish_test();
   end

   // Watchdog against a hung sequence
   initial
   begin
      #100000;
      errors++;
      finish_test();
   end
endmodule : tb
`default_nettype wire
